// ==== core/adsp_serial_port.sv ====
// What this block does
// - the serial port works only while chip select is low, and the data output floats while high.
// - output bits are launched on falling clock edges in modes 00, 01 and 10, rising in mode 11.
// - input bits are captured on the falling clock edge, where the master must have them ready.
// - end of conversion goes low on completion, and the result is readable only after it falls.
// - a low dac load input makes the dac registers follow the input registers, free of the serial clock.
// - at power-up all dac input registers hold all ones if the select pin is high, else zeros.
// - the select pin picks the wake-up termination, to reference when high and to ground when low.
`timescale 1ns/10ps
module adsp_serial_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    output logic sdoOut,
    output logic sdoOe,
    input wire logic [1:0] clkMode,
    // conversion side
    input wire logic convDone,
    input wire logic [15:0] convResult,
    output logic eocN,
    // dac pins and outputs
    input wire logic dacLoadN,
    input wire logic dacPowerupSelect,
    output logic dacTermToRef,
    output logic [7:0][11:0] dacOut,
    // received words
    output logic [15:0] rxWord,
    output logic rxValid,
    input wire logic rxReady,
    output logic wordLost
);
    // pin synchronisers; stage one is read by stage two only
    logic sclkS1, sclkS2, sclkS3, csS1, csS2, csS3, dinS1, dinS2;
    logic ldS1, ldS2, selS1, selS2;
    logic [1:0] modeS1, modeS2;

    always_ff @(posedge ref_clk)
    begin
        sclkS1 <= sclk;
        sclkS2 <= sclkS1;
        sclkS3 <= sclkS2;
        csS1 <= csN;
        csS2 <= csS1;
        csS3 <= csS2;
        dinS1 <= din;
        dinS2 <= dinS1;
        ldS1 <= dacLoadN;
        ldS2 <= ldS1;
        selS1 <= dacPowerupSelect;
        selS2 <= selS1;
        // the mode pins are strapped from outside, so they take the same two stages
        modeS1 <= clkMode;
        modeS2 <= modeS1;
    end

    // edge detection on synchronised pins
    logic sclkRise, sclkFall, csActive, csFallEvt, launchEdge;
    assign sclkRise = sclkS2 & ~sclkS3;
    assign sclkFall = ~sclkS2 & sclkS3;
    assign csActive = ~csS2;
    assign csFallEvt = ~csS2 & csS3;
    assign launchEdge = (adsp_pkg::adsp_ckmode_t'(modeS2) == adsp_pkg::CKMODE_11)
        ? sclkRise : sclkFall;

    // serial shift state
    logic [15:0] shIn, shOut, resultReg, next_shIn, next_shOut, next_resultReg;
    logic [3:0] bitCnt, next_bitCnt;
    logic next_eocN, next_sdoOe, next_wordLost;
    logic wordDone;

    adsp_stream_if #(.WIDTH(adsp_pkg::WORD_BITS)) pushSide ();
    adsp_stream_if #(.WIDTH(adsp_pkg::WORD_BITS)) popSide ();

    assign wordDone = csActive & sclkFall & (bitCnt == adsp_pkg::LAST_BIT);
    assign pushSide.valid = wordDone;
    assign pushSide.data = {shIn[14:0], dinS2};

    // shift in, shift out and end-of-conversion next values
    always_comb
    begin
        next_shIn = shIn;
        next_bitCnt = bitCnt;
        next_shOut = shOut;
        next_resultReg = resultReg;
        next_eocN = eocN;
        next_sdoOe = csActive;
        next_wordLost = wordDone & ~pushSide.ready;
        if (!csActive)
        begin
            next_bitCnt = '0;
            next_shIn = '0;
        end
        else if (sclkFall)
        begin
            next_shIn = {shIn[14:0], dinS2};
            next_bitCnt = 4'(bitCnt + 1'b1);
        end
        if (csFallEvt)
        begin
            next_shOut = resultReg; // first bit stands from chip select fall
            next_eocN = 1'b1;
        end
        else if (csActive && launchEdge)
            next_shOut = {shOut[14:0], 1'b0};
        // completion wins over the rearm at chip select fall
        if (convDone)
        begin
            next_resultReg = convResult;
            next_eocN = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            shIn <= '0;
            bitCnt <= '0;
            shOut <= '0;
            resultReg <= '0;
            eocN <= 1'b1;
            sdoOe <= 1'b0;
            wordLost <= 1'b0;
        end
        else
        begin
            shIn <= next_shIn;
            bitCnt <= next_bitCnt;
            shOut <= next_shOut;
            resultReg <= next_resultReg;
            eocN <= next_eocN;
            sdoOe <= next_sdoOe;
            wordLost <= next_wordLost;
        end
    end
    assign sdoOut = shOut[15];

    // a full fifo drops the word and flags it; the master cannot be stalled
    adsp_fifo #(.WIDTH(adsp_pkg::WORD_BITS), .DEPTH(adsp_pkg::FIFO_DEPTH)) rxFifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inSide(pushSide),
        .outSide(popSide)
    );
    assign rxWord = popSide.data;
    assign rxValid = popSide.valid;
    assign popSide.ready = rxReady;

    // dac input and output registers
    logic [7:0][11:0] dacInput, next_dacInput, next_dacOut;
    logic [2:0] wrCh;
    logic dacWrite;
    logic [11:0] powerupCode;

    assign dacWrite = popSide.valid & rxReady & popSide.data[adsp_pkg::DAC_WRITE_BIT];
    assign wrCh = popSide.data[adsp_pkg::DAC_CH_MSB:adsp_pkg::DAC_CH_LSB];
    assign powerupCode = selS2 ? adsp_pkg::DAC_CODE_ONES : adsp_pkg::DAC_CODE_ZEROS;

    // popped words with the write bit set update one channel
    always_comb
    begin
        next_dacInput = dacInput;
        if (dacWrite)
            next_dacInput[wrCh] = popSide.data[adsp_pkg::DAC_DATA_MSB:0];
        // the load pin is sampled by ref_clk only, never by the serial clock
        next_dacOut = ldS2 ? dacOut : dacInput;
    end

    // synchronous reset catches the strap; hold reset three edges so it settles
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dacInput <= {adsp_pkg::DAC_CHANNELS{powerupCode}};
            dacOut <= {adsp_pkg::DAC_CHANNELS{powerupCode}};
            dacTermToRef <= selS2;
        end
        else
        begin
            dacInput <= next_dacInput;
            dacOut <= next_dacOut;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence csRiseSeq;
        csActive ##1 !csActive;
    endsequence

    sequence launchSeq;
        csActive && !csFallEvt && launchEdge;
    endsequence

    chk_dout_float: assert property (!csActive |=> !sdoOe)
        else $error("data output driven while chip select high");
    chk_dout_drive: assert property (csActive [*2] |-> sdoOe)
        else $error("data output floats while selected");
    chk_launch_shift: assert property (launchSeq |=> shOut == {$past(shOut[14:0]), 1'b0})
        else $error("output did not advance on launch edge");
    chk_nonlaunch_hold: assert property (csActive && !csFallEvt && !launchEdge && !convDone
        |=> $stable(shOut))
        else $error("output moved off the launch edge");
    chk_capture_fall: assert property (csActive && sclkFall && !wordDone
        |=> shIn[0] == $past(dinS2))
        else $error("input bit not captured on falling edge");
    chk_eoc_done: assert property (convDone |=> !eocN && resultReg == $past(convResult))
        else $error("end of conversion or result wrong after completion");
    chk_eoc_hold: assert property (!eocN && !csFallEvt && !convDone |=> !eocN)
        else $error("end of conversion released early");
    chk_dac_follow: assert property (!ldS2 |=> dacOut == $past(dacInput))
        else $error("dac outputs not transparent under load");
    chk_dac_latch: assert property (ldS2 [*2] |-> $stable(dacOut))
        else $error("dac outputs moved without load");
    chk_powerup_code: assert property (disable iff (1'b0) !rst_n ##1 rst_n
        |-> dacInput[0] == {12{dacTermToRef}})
        else $error("power-up code does not match select");
    // three reset edges first: the strap synchroniser holds unknowns until it has filled
    chk_term_select: assert property (disable iff (1'b0) !rst_n [*3]
        |=> dacTermToRef == $past(selS2))
        else $error("termination select not taken at reset");
    chk_abort_word: assert property (csRiseSeq |=> bitCnt == '0 && shIn == '0)
        else $error("partial word survived chip select rise");
endmodule

// ==== shared/adsp_pkg.sv ====
package adsp_pkg;
    // serial word layout
    localparam int WORD_BITS = 16;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam int DAC_WRITE_BIT = 15;
    localparam int DAC_CH_MSB = 14;
    localparam int DAC_CH_LSB = 12;
    localparam int DAC_DATA_MSB = 11;
    // converter geometry
    localparam int DAC_BITS = 12;
    localparam int DAC_CHANNELS = 8;
    localparam int FIFO_DEPTH = 8;
    // power-up codes of the dac input registers
    localparam logic [11:0] DAC_CODE_ONES = 12'hFFF;
    localparam logic [11:0] DAC_CODE_ZEROS = 12'h000;
    // clock modes
    typedef enum logic [1:0]
    {
        CKMODE_00 = 2'h0,
        CKMODE_01 = 2'h1,
        CKMODE_10 = 2'h2,
        CKMODE_11 = 2'h3
    } adsp_ckmode_t;
endpackage

// ==== shared/adsp_stream_if.sv ====
`timescale 1ns/10ps
interface adsp_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== core/adsp_fifo.sv ====
`timescale 1ns/10ps
module adsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // filling and draining sides
    adsp_stream_if.snk inSide,
    adsp_stream_if.src outSide
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [CW-1:0] count, next_count;
    logic doPush, doPop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // honest full and empty; the drain side may stall and fill us up
    assign inSide.ready = (count != FULL_COUNT);
    assign outSide.valid = (count != '0);
    assign outSide.data = mem[rdPtr];
    assign doPush = inSide.valid & inSide.ready;
    assign doPop = outSide.valid & outSide.ready;

    // pointer and occupancy next values
    always_comb
    begin
        next_wrPtr = doPush ? bump(wrPtr) : wrPtr;
        next_rdPtr = doPop ? bump(rdPtr) : rdPtr;
        next_count = count;
        if (doPush && !doPop)
            next_count = CW'(count + 1'b1);
        else if (doPop && !doPush)
            next_count = CW'(count - 1'b1);
    end

    // storage carries no reset; only occupancy decides what is valid
    always_ff @(posedge ref_clk)
    begin
        if (doPush)
            mem[wrPtr] <= inSide.data;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end
endmodule

// ==== tb/adsp_spi_master.sv ====
`timescale 1ns/10ps
module adsp_spi_master (
    // serial pins towards the port
    output logic sclk,
    output logic csN,
    output logic din,
    input wire logic sdo,
    // launch edge of the port
    input wire logic [1:0] clkMode
);
    // clock stands still low between frames
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        din = 1'b0;
    end
    task automatic sel();
        csN = 1'b0;
        #300;
    endtask
    // flip din on release so a stale bit never looks like data
    task automatic desel();
        #100;
        csN = 1'b1;
        din = ~din;
        #300;
    endtask
    // msb first; din is set well before the fall and held past it
    task automatic word(input logic [15:0] w, input int nb, output logic [15:0] rd);
        for (int i = 15; i > 15 - nb; i--)
        begin
            #100 din = w[i];
            #100;
            if (clkMode == adsp_pkg::CKMODE_11)
                rd[i] = sdo;
            sclk = 1'b1;
            #200;
            if (clkMode != adsp_pkg::CKMODE_11)
                rd[i] = sdo;
            sclk = 1'b0;
        end
    endtask
endmodule

// ==== tb/test_adsp_serial_port.sv ====
`timescale 1ns/10ps
module test_adsp_serial_port;
    logic ref_clk, rst_n, sclk, csN, din, convDone, dacLoadN, dacPowerupSelect, rxReady, holdRx;
    logic sdoOut, sdoOe, eocN, dacTermToRef, rxValid, wordLost;
    logic [1:0] clkMode;
    logic [15:0] convResult, rxWord, rd, w;
    logic [7:0][11:0] dacOut;
    logic [11:0] codes [8];
    logic [15:0] expq [$];
    int fails = 0;
    int tests_run = 0;
    int lost = 0;
    int cycles = 0;
    // released output floats
    wire sdoLine = sdoOe ? sdoOut : 1'bz;

    adsp_serial_port adsp_serial_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
        .csN(csN), .din(din), .sdoOut(sdoOut), .sdoOe(sdoOe), .clkMode(clkMode),
        .convDone(convDone), .convResult(convResult), .eocN(eocN), .dacLoadN(dacLoadN),
        .dacPowerupSelect(dacPowerupSelect), .dacTermToRef(dacTermToRef), .dacOut(dacOut),
        .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady), .wordLost(wordLost));
    adsp_spi_master adsp_spi_master_i (.sclk(sclk), .csN(csN), .din(din), .sdo(sdoLine),
        .clkMode(clkMode));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset(input logic s);
        rst_n = 1'b0;
        dacPowerupSelect = s;
        repeat (20) tick();
        rst_n = 1'b1;
        tick();
        for (int c = 0; c < 8; c++)
            chk("dacOut", s ? 16'h0FFF : 16'h0000, {4'h0, dacOut[c]});
        chk("dacTermToRef", {15'h0, s}, {15'h0, dacTermToRef});
        chk("sdoOe", 16'h0000, {15'h0, sdoOe});
    endtask

    // one word in its own frame, noted as expected at the receive side
    task automatic frame(input logic [15:0] v);
        expq.push_back(v);
        adsp_spi_master_i.sel();
        adsp_spi_master_i.word(v, 16, rd);
        adsp_spi_master_i.desel();
    endtask

    // bounded wait for the user side to empty the queue of notes
    task automatic drain();
        for (int i = 0; i < 400 && expq.size() != 0; i++)
            tick();
        chk("pending", 16'h0000, 16'(expq.size()));
    endtask

    // user side pops at random unless the fill test stalls it
    always @(posedge ref_clk)
    begin
        #1 rxReady = ~holdRx & 1'($urandom);
    end

    // receive monitor takes the oldest note per popped word; it looks mid-cycle,
    // where valid, data and ready have settled before the popping edge
    always @(negedge ref_clk)
    begin
        if (rst_n === 1'b1 && rxValid === 1'b1 && rxReady === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                $display("MISMATCH rxWord expected none seen %h", rxWord);
                fails++;
            end
            else
                chk("rxWord", expq.pop_front(), rxWord);
        end
        if (wordLost === 1'b1)
            lost++;
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        {convDone, dacLoadN, holdRx, rxReady, rst_n} = 5'h0A;
        {clkMode, convResult, dacPowerupSelect} = '0;
        void'($urandom(32'hD8525589));
        do_reset(1'b1);
        // every mode: result read out while a data word goes in
        for (int m = 0; m < 4; m++)
        begin
            tick();
            clkMode = 2'(m);
            convResult = 16'($urandom);
            convDone = 1'b1;
            tick();
            convDone = 1'b0;
            tick();
            chk("eocN", 16'h0000, {15'h0, eocN});
            w = 16'($urandom) & 16'h7FFF;
            expq.push_back(w);
            adsp_spi_master_i.sel();
            chk("sdoOe", 16'h0001, {15'h0, sdoOe});
            chk("eocN", 16'h0001, {15'h0, eocN});
            adsp_spi_master_i.word(w, 16, rd);
            adsp_spi_master_i.desel();
            chk("sdoOut", convResult, rd);
            chk("sdoOe", 16'h0000, {15'h0, sdoOe});
        end
        // a word cut short by deselect must vanish
        adsp_spi_master_i.sel();
        adsp_spi_master_i.word(16'h5A5A, 7, rd);
        adsp_spi_master_i.desel();
        frame(16'h0000 | 16'($urandom) & 16'h7FFF);
        drain();
        // stalled user side: eight words fit, the ninth is dropped
        holdRx = 1'b1;
        tick();
        adsp_spi_master_i.sel();
        for (int k = 0; k < 9; k++)
        begin
            w = 16'($urandom) & 16'h7FFF;
            if (k < 8)
                expq.push_back(w);
            adsp_spi_master_i.word(w, 16, rd);
        end
        adsp_spi_master_i.desel();
        chk("wordLost", 16'h0001, 16'(lost));
        holdRx = 1'b0;
        drain();
        // dac writes stay hidden until load goes low
        for (int c = 0; c < 8; c++)
        begin
            codes[c] = 12'($urandom);
            frame({1'b1, 3'(c), codes[c]});
        end
        drain();
        for (int c = 0; c < 8; c++)
            chk("dacOut", 16'h0FFF, {4'h0, dacOut[c]});
        dacLoadN = 1'b0;
        repeat (4) tick();
        for (int c = 0; c < 8; c++)
            chk("dacOut", {4'h0, codes[c]}, {4'h0, dacOut[c]});
        dacLoadN = 1'b1;
        do_reset(1'b0);
        stop_test();
    end
endmodule
